// File: hw/port_bus_pkg.sv
package port_bus_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int OSC_DIV = 4; // mclk cycles per oscillator period
	localparam int DIV_W = $clog2(OSC_DIV);
	localparam logic [DIV_W-1:0] OSC_DIV_LAST = DIV_W'(OSC_DIV - 1);
	localparam int OSC_PER_MCYCLE = 12;
	localparam int RESET_MCYCLES = 2;
	localparam int RESET_OSC_PERIODS = RESET_MCYCLES * OSC_PER_MCYCLE;
	localparam logic [4:0] RESET_COUNT_FULL = 5'(RESET_OSC_PERIODS);

	// ----------------------------------------
	// Phases of a machine cycle (oscillator periods)
	// ----------------------------------------
	localparam logic [3:0] PH_FIRST = 4'h0;
	localparam logic [3:0] PH_LAST = 4'(OSC_PER_MCYCLE - 1);
	localparam logic [3:0] PH_HALF = 4'h6;
	localparam logic [3:0] PH_ALE_END_A = 4'h1;
	localparam logic [3:0] PH_ALE_END_B = 4'h7;
	localparam logic [3:0] PH_ADDR_END_A = 4'h2;
	localparam logic [3:0] PH_ADDR_END_B = 4'h8;
	localparam logic [3:0] PH_STROBE_A = 4'h3;
	localparam logic [3:0] PH_SAMPLE_A = 4'h5;
	localparam logic [3:0] PH_STROBE_B = 4'h9;
	localparam logic [3:0] PH_SAMPLE_B = 4'hB;
	localparam logic [3:0] PH_XSAMPLE = 4'hA;

	// ----------------------------------------
	// Values and pin positions
	// ----------------------------------------
	localparam logic [15:0] INT_ROM_TOP = 16'h3FFF;
	localparam logic [7:0] PORT_RESET = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int BIT_TIMER_C_CLK = 0;
	localparam int BIT_TIMER_C_TRIG = 1;
	localparam int BIT_SERIAL_RX = 0;
	localparam int BIT_SERIAL_TX = 1;
	localparam int BIT_IRQ_A = 2;
	localparam int BIT_IRQ_B = 3;
	localparam int BIT_TIMER_A = 4;
	localparam int BIT_TIMER_B = 5;
	localparam int BIT_XWRITE = 6;
	localparam int BIT_XREAD = 7;
	localparam int SYNC_W = 34;

	typedef enum logic [1:0] {
		CYC_IDLE = 2'b00,
		CYC_FETCH = 2'b01,
		CYC_DATA = 2'b11
	} cycle_t;

endpackage

// File: hw/osc_divider.sv
`timescale 1ns/1ns
`default_nettype none

module osc_divider import port_bus_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic run,
	output logic tick
);

	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic tick;
	} div_t;

	div_t s;
	div_t next_s;

	// One tick per oscillator period, none while stopped
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (run) begin
			if (s.count == OSC_DIV_LAST) begin
				next_s.count = '0;
				next_s.tick = 1'b1;
			end else begin
				next_s.count = s.count + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule // osc_divider

`default_nettype wire

// File: hw/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync import port_bus_pkg::*; (
	input wire logic mclk,
	input wire logic [SYNC_W-1:0] pinIn,
	output logic [SYNC_W-1:0] pinSync
);

	typedef struct packed {
		logic [SYNC_W-1:0] first;
		logic [SYNC_W-1:0] second;
	} sync_t;

	sync_t s;
	sync_t next_s;

	// Two flops per pin; first stage read only by second
	always_comb begin
		next_s.first = pinIn;
		next_s.second = s.first;
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_bit
			assign pinSync[i] = s.second[i];
		end
	endgenerate

endmodule // pin_sync

`default_nettype wire

// File: hw/external_memory_port_interface.sv
`timescale 1ns/1ns
`default_nettype none

module external_memory_port_interface import port_bus_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic resetPin,
	input wire logic extAccessSelect,
	input wire logic [7:0] port0In,
	input wire logic [7:0] port1In,
	input wire logic [7:0] port2In,
	input wire logic [7:0] port3In,
	output logic [7:0] port0Out,
	output logic [7:0] port0Oe,
	output logic [7:0] port1Out,
	output logic [7:0] port1Oe,
	output logic [7:0] port2Out,
	output logic [7:0] port2Oe,
	output logic [7:0] port3Out,
	output logic [7:0] port3Oe,
	output logic addressLatchStrobe,
	output logic progStoreReadStrobeN,
	input wire logic [7:0] portZeroLatch,
	input wire logic [7:0] portOneLatch,
	input wire logic [7:0] portTwoLatch,
	input wire logic [7:0] portThreeLatch,
	input wire logic [15:0] fetchAddr,
	input wire logic xdataReq,
	input wire logic xdataWrite,
	input wire logic xdataWide,
	input wire logic [15:0] xdataAddr,
	input wire logic [7:0] xdataWdata,
	input wire logic serialTx,
	input wire logic idleMode,
	input wire logic powerDown,
	input wire logic progVerify,
	input wire logic [7:0] verifyCode,
	output logic cycleStart,
	output logic [7:0] codeByte,
	output logic codeValid,
	output logic [7:0] xdataRdata,
	output logic xdataDone,
	output logic cpuReset,
	output logic [7:0] port0Pins,
	output logic [7:0] port1Pins,
	output logic [7:0] port2Pins,
	output logic [7:0] port3Pins,
	output logic timerCExtClock,
	output logic timerCTrigger,
	output logic serialRx,
	output logic extIrqA,
	output logic extIrqB,
	output logic timerAInput,
	output logic timerBInput
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		cycle_t state;
		logic [3:0] phase;
		logic extFetch;
		logic [15:0] addr;
		logic xWrite;
		logic xWide;
		logic [7:0] wdata;
		logic [4:0] rstCount;
		logic cpuReset;
		logic cycleStart;
		logic [7:0] codeByte;
		logic codeValid;
		logic [7:0] xdataRdata;
		logic xdataDone;
		logic ale;
		logic psenN;
		logic rdN;
		logic wrN;
		logic [7:0] p0Out;
		logic [7:0] p0Oe;
		logic [7:0] p1Out;
		logic [7:0] p1Oe;
		logic [7:0] p2Out;
		logic [7:0] p2Oe;
		logic [7:0] p3Out;
		logic [7:0] p3Oe;
	} state_t;

	localparam state_t STATE_RESET = '{
		state: CYC_IDLE,
		phase: PH_FIRST,
		extFetch: 1'b0,
		addr: 16'h0000,
		xWrite: 1'b0,
		xWide: 1'b0,
		wdata: BYTE_ZERO,
		rstCount: 5'h00,
		cpuReset: 1'b1,
		cycleStart: 1'b0,
		codeByte: BYTE_ZERO,
		codeValid: 1'b0,
		xdataRdata: BYTE_ZERO,
		xdataDone: 1'b0,
		ale: 1'b1,
		psenN: 1'b1,
		rdN: 1'b1,
		wrN: 1'b1,
		p0Out: PORT_RESET,
		p0Oe: BYTE_ZERO,
		p1Out: PORT_RESET,
		p1Oe: BYTE_ZERO,
		p2Out: PORT_RESET,
		p2Oe: BYTE_ZERO,
		p3Out: PORT_RESET,
		p3Oe: BYTE_ZERO
	};

	state_t s;
	state_t n;

	// ----------------------------------------
	// Pin synchronisers and oscillator divider
	// ----------------------------------------
	logic [SYNC_W-1:0] syncOut;
	logic oscTick;
	logic rstPinS;
	logic extSelS;
	logic [7:0] p0S;
	logic [7:0] p1S;
	logic [7:0] p2S;
	logic [7:0] p3S;

	pin_sync u_sync (
		.mclk(mclk),
		.pinIn({resetPin, extAccessSelect, port3In, port2In, port1In, port0In}),
		.pinSync(syncOut)
	);

	assign {rstPinS, extSelS, p3S, p2S, p1S, p0S} = syncOut;

	// Oscillator halts in power-down until the reset pin frees it
	osc_divider u_div (
		.mclk(mclk),
		.reset(reset),
		.run(~powerDown | rstPinS),
		.tick(oscTick)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic halted;
	logic busFetch;
	logic busData;
	logic addrPhase;
	logic secondHalf;
	logic [15:0] halfAddr;

	always_comb begin
		n = s;
		n.cycleStart = 1'b0;
		n.codeValid = 1'b0;
		n.xdataDone = 1'b0;

		// Reset pin length, counted in oscillator periods
		if (!rstPinS) begin
			n.rstCount = 5'h00;
		end else if (oscTick && s.rstCount != RESET_COUNT_FULL) begin
			n.rstCount = s.rstCount + 5'h01;
		end
		n.cpuReset = rstPinS && (s.rstCount == RESET_COUNT_FULL);

		// Machine cycle sequencer
		halted = rstPinS | s.cpuReset | powerDown | idleMode | progVerify;
		if (halted) begin
			n.state = CYC_IDLE;
			n.phase = PH_FIRST;
		end else if (oscTick) begin
			// Capture code bytes at the end of each strobe window
			if (s.state == CYC_FETCH && s.extFetch &&
				(s.phase == PH_SAMPLE_A || s.phase == PH_SAMPLE_B)) begin
				n.codeByte = p0S;
				n.codeValid = 1'b1;
			end
			// Read data taken just before the read strobe ends
			if (s.state == CYC_DATA && !s.xWrite && s.phase == PH_XSAMPLE) begin
				n.xdataRdata = p0S;
			end
			if (s.state == CYC_DATA && s.phase == PH_LAST) begin
				n.xdataDone = 1'b1;
			end
			if (s.state == CYC_IDLE || s.phase == PH_LAST) begin
				n.phase = PH_FIRST;
				n.cycleStart = 1'b1;
				n.extFetch = ~extSelS | (fetchAddr > INT_ROM_TOP);
				n.xWrite = xdataWrite;
				n.xWide = xdataWide;
				n.wdata = xdataWdata;
				if (xdataReq) begin
					n.state = CYC_DATA;
					n.addr = xdataAddr;
				end else begin
					n.state = CYC_FETCH;
					n.addr = fetchAddr;
				end
			end else begin
				n.phase = s.phase + 4'h1;
			end
		end

		// Phase decode of the coming cycle
		secondHalf = n.phase >= PH_HALF;
		addrPhase = (n.phase <= PH_ADDR_END_A) ||
			(secondHalf && n.phase <= PH_ADDR_END_B);
		halfAddr = (secondHalf && n.state == CYC_FETCH) ? n.addr + 16'h0001 : n.addr;
		busFetch = (n.state == CYC_FETCH) && n.extFetch;
		busData = (n.state == CYC_DATA);

		// Strobes
		n.ale = 1'b0;
		n.psenN = 1'b1;
		n.rdN = 1'b1;
		n.wrN = 1'b1;
		if (n.state != CYC_IDLE) begin
			if (n.phase <= PH_ALE_END_A) begin
				n.ale = 1'b1;
			end else if (secondHalf && n.phase <= PH_ALE_END_B && !busData) begin
				n.ale = 1'b1;
			end
			if (busFetch && ((n.phase >= PH_STROBE_A && n.phase <= PH_SAMPLE_A) ||
				n.phase >= PH_STROBE_B)) begin
				n.psenN = 1'b0;
			end
			if (busData && n.phase >= PH_STROBE_A && n.phase <= PH_XSAMPLE) begin
				n.wrN = ~n.xWrite;
				n.rdN = n.xWrite;
			end
		end

		// Port-data mode: open drain on zero, quasi on the rest
		n.p0Out = portZeroLatch;
		n.p0Oe = ~portZeroLatch;
		n.p1Out = portOneLatch;
		n.p1Oe = ~portOneLatch;
		n.p2Out = portTwoLatch;
		n.p2Oe = ~portTwoLatch;
		n.p3Out = portThreeLatch;
		n.p3Out[BIT_SERIAL_TX] = portThreeLatch[BIT_SERIAL_TX] & serialTx;
		n.p3Out[BIT_XWRITE] = portThreeLatch[BIT_XWRITE] & n.wrN;
		n.p3Out[BIT_XREAD] = portThreeLatch[BIT_XREAD] & n.rdN;
		n.p3Oe = ~n.p3Out;

		if (rstPinS || s.cpuReset) begin
			// Ports forced high as soon as the pin is seen
			n.p0Out = PORT_RESET;
			n.p0Oe = BYTE_ZERO;
			n.p1Out = PORT_RESET;
			n.p1Oe = BYTE_ZERO;
			n.p2Out = PORT_RESET;
			n.p2Oe = BYTE_ZERO;
			n.p3Out = PORT_RESET;
			n.p3Oe = BYTE_ZERO;
			n.ale = 1'b1;
			n.psenN = 1'b1;
		end else if (progVerify) begin
			// Code out on zero, address and controls in on one and two
			n.p0Out = verifyCode;
			n.p0Oe = ~verifyCode;
			n.p1Out = PORT_RESET;
			n.p1Oe = BYTE_ZERO;
			n.p2Out = PORT_RESET;
			n.p2Oe = BYTE_ZERO;
		end else if (powerDown) begin
			// Both strobes low, bus floated, latch data back on two
			n.ale = 1'b0;
			n.psenN = 1'b0;
			if (s.extFetch) begin
				n.p0Oe = BYTE_ZERO;
			end
		end else if (idleMode) begin
			n.ale = 1'b1;
			n.psenN = 1'b1;
			if (s.extFetch) begin
				n.p0Oe = BYTE_ZERO;
				n.p2Out = s.addr[15:8];
				n.p2Oe = PORT_RESET;
			end
		end else if (busFetch || busData) begin
			// Multiplexed bus: address while the latch strobe is up
			if (addrPhase && !(busData && secondHalf)) begin
				n.p0Out = halfAddr[7:0];
				n.p0Oe = PORT_RESET;
			end else if (busData && n.xWrite) begin
				n.p0Out = n.wdata;
				n.p0Oe = PORT_RESET;
			end else begin
				n.p0Out = PORT_RESET;
				n.p0Oe = BYTE_ZERO;
			end
			if (busFetch || n.xWide) begin
				n.p2Out = halfAddr[15:8];
				n.p2Oe = PORT_RESET;
			end else begin
				n.p2Out = portTwoLatch;
				n.p2Oe = ~portTwoLatch;
			end
		end
	end

	// ----------------------------------------
	// Register
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			s <= STATE_RESET;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign port0Out = s.p0Out;
	assign port0Oe = s.p0Oe;
	assign port1Out = s.p1Out;
	assign port1Oe = s.p1Oe;
	assign port2Out = s.p2Out;
	assign port2Oe = s.p2Oe;
	assign port3Out = s.p3Out;
	assign port3Oe = s.p3Oe;
	assign addressLatchStrobe = s.ale;
	assign progStoreReadStrobeN = s.psenN;
	assign cycleStart = s.cycleStart;
	assign codeByte = s.codeByte;
	assign codeValid = s.codeValid;
	assign xdataRdata = s.xdataRdata;
	assign xdataDone = s.xdataDone;
	assign cpuReset = s.cpuReset;

	// Synchronised pin levels and alternate inputs
	assign port0Pins = p0S;
	assign port1Pins = p1S;
	assign port2Pins = p2S;
	assign port3Pins = p3S;
	assign timerCExtClock = p1S[BIT_TIMER_C_CLK];
	assign timerCTrigger = p1S[BIT_TIMER_C_TRIG];
	assign serialRx = p3S[BIT_SERIAL_RX];
	assign extIrqA = p3S[BIT_IRQ_A];
	assign extIrqB = p3S[BIT_IRQ_B];
	assign timerAInput = p3S[BIT_TIMER_A];
	assign timerBInput = p3S[BIT_TIMER_B];

endmodule // external_memory_port_interface

`default_nettype wire

// File: sim/port_bus_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Pin timing checker
// ----------------------------------------
module port_bus_properties import port_bus_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic resetPin,
	input wire logic extAccessSelect,
	input wire logic xdataReq,
	input wire logic xdataWide,
	input wire logic [15:0] xdataAddr,
	input wire logic [15:0] fetchAddr,
	input wire logic idleMode,
	input wire logic powerDown,
	input wire logic progVerify,
	input wire logic [7:0] portTwoLatch,
	input wire logic [7:0] port1Oe,
	input wire logic [7:0] port2Out,
	input wire logic [7:0] port2Oe,
	input wire logic [7:0] port3Out,
	input wire logic [7:0] port3Oe,
	input wire logic addressLatchStrobe,
	input wire logic progStoreReadStrobeN,
	input wire logic cycleStart,
	input wire logic xdataDone,
	input wire logic cpuReset
);
	logic quiet;
	logic cWide;
	logic [7:0] cHi, pinHigh;
	logic [2:0] psFalls, aleFalls;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Modes in which no bus cycles run
	assign quiet = reset | resetPin | idleMode | powerDown | progVerify | cpuReset;
	// Reset pin time and per-cycle strobe counts
	always_ff @(posedge mclk) begin
		pinHigh <= resetPin ? (pinHigh == 8'hFF ? pinHigh : pinHigh + 8'h01) : 8'h00;
		psFalls <= cycleStart ? 3'h0 : psFalls + {2'h0, $fell(progStoreReadStrobeN)};
		aleFalls <= cycleStart ? 3'h0 : aleFalls + {2'h0, $fell(addressLatchStrobe)};
		if (cycleStart) begin
			cWide <= $past(xdataWide);
			cHi <= $past(xdataAddr[15:8]);
		end
	end
	a_pin_force_ones: assert property (resetPin[*4] |-> (port1Oe | port2Oe | port3Oe) == 8'h00)
		else $error("ports not released to ones under reset pin");
	a_cpu_reset_min: assert property ($rose(cpuReset) |-> pinHigh >= 8'h5A)
		else $error("core reset after too short a pin pulse");
	a_cpu_reset_max: assert property (pinHigh == 8'h6E |-> cpuReset)
		else $error("core reset missing after long pin pulse");
	a_ale_pulse_width: assert property (disable iff (quiet)
		$rose(addressLatchStrobe) |-> addressLatchStrobe[*8] ##1 !addressLatchStrobe)
		else $error("latch strobe width wrong");
	a_ps_low_span: assert property (disable iff (quiet)
		$fell(progStoreReadStrobeN) |-> ##11 !progStoreReadStrobeN ##1 progStoreReadStrobeN)
		else $error("program strobe width wrong");
	a_data_cycle_skips: assert property (disable iff (quiet)
		xdataDone |-> psFalls == 3'h0 && aleFalls == 3'h1)
		else $error("strobes not skipped in data cycle");
	a_ps_internal_quiet: assert property (disable iff (quiet)
		cycleStart && $past(extAccessSelect, 4) && $past(extAccessSelect)
		&& $past(fetchAddr) <= INT_ROM_TOP && !$past(xdataReq)
		|-> ##8 progStoreReadStrobeN[*8])
		else $error("program strobe on internal fetch");
	a_read_strobe_len: assert property (disable iff (quiet)
		$fell(port3Out[7]) |-> ##31 !port3Out[7] ##1 port3Out[7])
		else $error("read strobe width wrong");
	a_wide_addr_hi: assert property (disable iff (quiet)
		!port3Out[7] && cWide |-> port2Out == cHi && port2Oe == 8'hFF)
		else $error("high address missing on wide access");
	a_short_keeps_latch: assert property (disable iff (quiet)
		!port3Out[7] && !cWide |-> port2Out == portTwoLatch)
		else $error("port two latch not kept on short access");
endmodule // port_bus_properties
`default_nettype wire

// File: sim/ext_memory_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// External code and data memory with address latch
// ----------------------------------------
module ext_memory_model (
	input wire logic mclk,
	input wire logic ale,
	input wire logic psN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [7:0] p0Out,
	input wire logic [7:0] p0Oe,
	input wire logic [7:0] p2Pin,
	output logic [7:0] p0Pin
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr;
	logic [7:0] last, drive;
	logic aleWas, wrWas;
	// Data memory preset to a known pattern
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h3C;
	end
	// Latch address on strobe fall, store on write strobe rise
	always @(posedge mclk) begin
		if (aleWas && !ale) addr <= {p2Pin, p0Pin};
		if (!wrWas && wrN) mem[addr] <= p0Pin;
		aleWas <= ale;
		wrWas <= wrN;
		last <= p0Pin;
	end
	// Code byte derived from address; released bus drifts away
	assign drive = !psN ? (addr[7:0] ^ addr[15:8] ^ 8'hA5) : mem[addr];
	assign p0Pin = (p0Oe & p0Out) | (~p0Oe & ((!psN || !rdN) ? drive : ~last));
endmodule // ext_memory_model
`default_nettype wire

// File: sim/external_memory_port_interface_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Bench for the port and memory bus block
// ----------------------------------------
module external_memory_port_interface_tb import port_bus_pkg::*;;
	typedef struct packed {
		logic sel;
		logic [1:0] op;
		logic wide;
		logic [15:0] addr;
		logic [7:0] wd;
		logic [7:0] exp;
	} row_t;
	logic mclk, reset, resetPin, extAccessSelect, xdataReq, xdataWrite, xdataWide, serialTx;
	logic idleMode, powerDown, progVerify, addressLatchStrobe, progStoreReadStrobeN, cycleStart;
	logic codeValid, xdataDone, cpuReset, timerCExtClock, timerCTrigger, serialRx, extIrqA;
	logic extIrqB, timerAInput, timerBInput, done;
	logic [15:0] fetchAddr, xdataAddr, code;
	logic [7:0] port0In, port1In, port2In, port3In, port0Out, port0Oe, port1Out, port1Oe;
	logic [7:0] port2Out, port2Oe, port3Out, port3Oe, portZeroLatch, portOneLatch, portTwoLatch;
	logic [7:0] portThreeLatch, xdataWdata, verifyCode, codeByte, xdataRdata, ext1, ext3;
	logic [7:0] port0Pins, port1Pins, port2Pins, port3Pins;
	int n_fail, checked, nAle, nPs;
	// Ops: 0 fetch, 1 read, 2 write
	row_t rows [9] = '{
		'{1'b0, 2'h0, 1'b0, 16'h0010, 8'h00, 8'h00},
		'{1'b1, 2'h0, 1'b0, 16'h4000, 8'h00, 8'h00},
		'{1'b1, 2'h0, 1'b0, 16'h3FFF, 8'h00, 8'h00},
		'{1'b1, 2'h2, 1'b1, 16'h8123, 8'hA7, 8'h00},
		'{1'b1, 2'h1, 1'b1, 16'h8123, 8'h00, 8'hA7},
		'{1'b1, 2'h2, 1'b0, 16'h0045, 8'h5E, 8'h00},
		'{1'b1, 2'h1, 1'b1, 16'h1245, 8'h00, 8'h5E},
		'{1'b1, 2'h1, 1'b0, 16'h0023, 8'h00, 8'h1F},
		'{1'b1, 2'h1, 1'b1, 16'h80FF, 8'h00, 8'hC3}
	};
	// Pull-ups on ports one to three, board may pull one and three low
	assign port1In = (port1Out | ~port1Oe) & ext1;
	assign port2In = port2Out | ~port2Oe;
	assign port3In = (port3Out | ~port3Oe) & ext3;
	external_memory_port_interface dut (.*);
	ext_memory_model mem (.mclk, .ale(addressLatchStrobe), .psN(progStoreReadStrobeN),
		.rdN(port3In[7]), .wrN(port3In[6]), .p0Out(port0Out), .p0Oe(port0Oe),
		.p2Pin(port2In), .p0Pin(port0In));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checked++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One machine cycle from its start: strobe falls, code bytes, completion
	task automatic observe();
		int k;
		logic aPrev, pPrev;
		k = 0;
		nAle = 0;
		nPs = 0;
		code = 16'h0000;
		done = 1'b0;
		do @(posedge mclk); while (!cycleStart && ++k < 100);
		if (k >= 100) n_fail++;
		aPrev = addressLatchStrobe;
		pPrev = progStoreReadStrobeN;
		repeat (48) begin
			@(posedge mclk);
			nAle += int'(aPrev && !addressLatchStrobe);
			nPs += int'(pPrev && !progStoreReadStrobeN);
			if (codeValid === 1'b1) code = {code[7:0], codeByte};
			done = done | (xdataDone === 1'b1);
			aPrev = addressLatchStrobe;
			pPrev = progStoreReadStrobeN;
		end
	endtask
	// Watchdog
	initial begin
		#60000;
		n_fail++;
		wrap_up();
	end
	initial begin
		{resetPin, xdataReq, xdataWrite, xdataWide, idleMode, powerDown, progVerify} = 7'h00;
		{reset, serialTx, extAccessSelect} = 3'h7;
		{fetchAddr, xdataAddr} = 32'h0000_0000;
		{portZeroLatch, portOneLatch, portThreeLatch, ext1, ext3} = 40'hFF_FF_FF_FF_FF;
		{portTwoLatch, xdataWdata, verifyCode} = 24'h12_00_00;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			extAccessSelect <= rows[i].sel;
			xdataReq <= rows[i].op != 2'h0;
			xdataWrite <= rows[i].op == 2'h2;
			xdataWide <= rows[i].wide;
			xdataAddr <= rows[i].addr;
			xdataWdata <= rows[i].wd;
			if (rows[i].op == 2'h0) fetchAddr <= rows[i].addr;
			observe();
			check(16'(nAle), rows[i].op == 2'h0 ? 16'h2 : 16'h1);
			check(16'(nPs), rows[i].op == 2'h0 && rows[i].addr != 16'h3FFF ? 16'h2 : 16'h0);
			check(16'(done), 16'(rows[i].op != 2'h0));
			if (rows[i].op == 2'h0 && rows[i].addr != 16'h3FFF)
				check(code, {rows[i].addr[7:0] ^ rows[i].addr[15:8] ^ 8'hA5,
					8'(rows[i].addr + 16'h1) ^ rows[i].addr[15:8] ^ 8'hA5});
			if (rows[i].op == 2'h1) check(16'(xdataRdata), 16'(rows[i].exp));
			$display("row %0d done", i);
		end
		// Port zero open-drain, pulled port one and timer pins
		xdataReq <= 1'b0;
		portZeroLatch <= 8'h0F;
		ext1 <= 8'hFE;
		repeat (100) @(posedge mclk);
		check(16'(port0Oe), 16'h00F0);
		check(16'(port1Pins), 16'h00FE);
		check(16'({timerCExtClock, timerCTrigger}), 16'h0001);
		$display("pin test done");
		// Idle then power-down while executing externally
		extAccessSelect <= 1'b0;
		repeat (100) @(posedge mclk);
		idleMode <= 1'b1;
		repeat (20) @(posedge mclk);
		check(16'({addressLatchStrobe, progStoreReadStrobeN, port0Oe}), 16'h0300);
		idleMode <= 1'b0;
		powerDown <= 1'b1;
		ext3 <= 8'hFB;
		repeat (20) @(posedge mclk);
		check(16'({addressLatchStrobe, progStoreReadStrobeN}), 16'h0000);
		check(16'({extIrqA, extIrqB, timerAInput, timerBInput, serialRx}), 16'h000F);
		check(16'(port3Pins), 16'h00FB);
		$display("mode test done");
		// Verify mode drives code open-drain, releases ports one and two
		powerDown <= 1'b0;
		progVerify <= 1'b1;
		verifyCode <= 8'h5A;
		repeat (20) @(posedge mclk);
		check(16'(port0Oe), 16'h00A5);
		check(16'(port0Out), 16'h005A);
		check(16'(port1Oe | port2Oe), 16'h0000);
		$display("verify test done");
		// Reset pin with oscillator stopped and ports driven low
		progVerify <= 1'b0;
		powerDown <= 1'b1;
		repeat (2) @(posedge mclk);
		{portOneLatch, portTwoLatch, portThreeLatch} <= 24'h00_00_00;
		repeat (10) @(posedge mclk);
		resetPin <= 1'b1;
		repeat (4) @(posedge mclk);
		check(16'(port1Oe | port2Oe | port3Oe), 16'h0000);
		// Pins lag through the synchroniser; board holds port one bit 0 low
		repeat (2) @(posedge mclk);
		check(16'({port1Pins, port2Pins}), 16'hFEFF);
		repeat (54) @(posedge mclk);
		check(16'(cpuReset), 16'h0000);
		{portOneLatch, portTwoLatch, portThreeLatch} <= 24'hFF_12_FF;
		repeat (50) @(posedge mclk);
		check(16'(cpuReset), 16'h0001);
		resetPin <= 1'b0;
		powerDown <= 1'b0;
		repeat (6) @(posedge mclk);
		check(16'(cpuReset), 16'h0000);
		$display("reset pin test done");
		wrap_up();
	end
endmodule // external_memory_port_interface_tb
bind external_memory_port_interface port_bus_properties chk (.*);
`default_nettype wire
